/* bench/nhpi_flash_model.sv */
// Behavioural flash device on the far side of the host pins.
// Assumes one host on the pins; busy times are scaled down from the typical figures.
`timescale 1ns/1ps
module nhpi_flash_model #(
  parameter int PROG_NS  = 20000,
  parameter int ERASE_NS = 40000,
  parameter int READ_NS  = 5000
) (
  input  wire logic       cs_n_in,
  input  wire logic       cle_in,
  input  wire logic       ale_in,
  input  wire logic       we_n_in,
  input  wire logic       re_n_in,
  input  wire logic       wp_n_in,
  input  wire logic [7:0] io_in,
  output logic      [7:0] io_out,
  output logic            io_en_out,
  output logic            rb_out,
  output logic            err_out
);
  typedef logic [7:0] nhpi_page_t [0:2111];
  nhpi_page_t mem [int];
  nhpi_page_t dreg;
  logic [7:0]  cmd;
  logic [7:0]  rd;
  logic [11:0] col;
  logic [15:0] row;
  int          na;
  logic        busy;
  initial begin
    busy = 0; err_out = 0; rd = 8'h00; na = 0; cmd = 8'hff; col = 0; row = 0;
  end
  assign rb_out    = !busy;
  assign io_en_out = !cs_n_in && !re_n_in;
  // A released bus shows the inverse of the last byte so stale data never matches.
  assign io_out    = io_en_out ? rd : ~rd;
  always @(posedge we_n_in) if (!cs_n_in) begin
    if (busy) err_out = 1;
    if (cle_in) begin
      cmd = io_in;
      na = 0;
      if (io_in == 8'h80) foreach (dreg[i]) dreg[i] = 8'hff;
      if (io_in == 8'h30 || (wp_n_in && (io_in == 8'h10 || io_in == 8'hd0))) busy = 1;
    end else if (ale_in) begin
      if (cmd == 8'h60) begin
        if (na == 0) row[7:0] = io_in;
        if (na == 1) row[15:8] = io_in;
      end else begin
        if (na == 0) col[7:0] = io_in;
        if (na == 1) begin
          col[11:8] = io_in[3:0];
          if (io_in[7:4] != 4'h0) err_out = 1;
        end
        if (na == 2) row[7:0] = io_in;
        if (na == 3) row[15:8] = io_in;
      end
      na++;
    end else if (cmd == 8'h80 && col < 12'd2112) begin
      dreg[col] = io_in;
      col++;
    end
  end
  always @(negedge re_n_in) if (!cs_n_in && col < 12'd2112) begin
    rd = dreg[col];
    col++;
  end
  // Busy runs to completion whatever chip select does.
  always @(posedge busy) begin
    if (cmd == 8'h10) begin
      #PROG_NS;
      mem[int'(row)] = dreg;
    end else if (cmd == 8'hd0) begin
      #ERASE_NS;
      for (int p = 0; p < 64; p++) mem.delete(int'({row[15:6], p[5:0]}));
    end else begin
      #READ_NS;
      if (mem.exists(int'(row))) dreg = mem[int'(row)];
      else foreach (dreg[i]) dreg[i] = 8'hff;
    end
    busy = 0;
  end
endmodule : nhpi_flash_model

/* bench/nhpi_host_checker.sv */
// Pin-level timing and ordering checks for the NAND host controller.
// Assumes it is bound to nhpi_host and sees only its ports.
`timescale 1ns/1ps
module nhpi_host_checker (
  input wire logic       core_clk_in,
  input wire logic       reset_n_in,
  input wire logic       chip_select_n_out,
  input wire logic       cmd_latch_out,
  input wire logic       addr_latch_out,
  input wire logic       write_strobe_n_out,
  input wire logic       read_strobe_n_out,
  input wire logic       write_protect_n_out,
  input wire logic [7:0] io_out,
  input wire logic       io_oe_n_out,
  input wire logic       ready_busy_in,
  input wire logic       op_done_out,
  input wire logic       rd_valid_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence two_low_s(sig);
    !sig [*2] ##1 sig;
  endsequence
  wr_pulse_a: assert property ($fell(write_strobe_n_out) |-> two_low_s(write_strobe_n_out))
    else $error("write strobe width wrong");
  wr_drive_a: assert property ($rose(write_strobe_n_out) |-> !io_oe_n_out && $stable(io_out))
    else $error("bus not driven at write strobe rise");
  latch_excl_a: assert property (!(cmd_latch_out && addr_latch_out))
    else $error("both latches high");
  addr_drive_a: assert property (addr_latch_out && !write_strobe_n_out |-> !io_oe_n_out)
    else $error("address cycle without bus drive");
  rd_pulse_a: assert property ($fell(read_strobe_n_out) |-> two_low_s(read_strobe_n_out))
    else $error("read strobe width wrong");
  no_clash_a: assert property (!read_strobe_n_out |-> io_oe_n_out && write_strobe_n_out)
    else $error("host drives bus during read");
  sel_hold_a: assert property (!write_strobe_n_out || !read_strobe_n_out |-> !chip_select_n_out)
    else $error("strobe without chip select");
  busy_quiet_a: assert property (!ready_busy_in [*3] |-> write_strobe_n_out && read_strobe_n_out)
    else $error("strobe while device busy");
  wp_hold_a: assert property (!chip_select_n_out && !$past(chip_select_n_out) |-> $stable(write_protect_n_out))
    else $error("write protect moved mid operation");
  done_pulse_a: assert property (op_done_out |=> !op_done_out && !rd_valid_out)
    else $error("done pulse too long");
endmodule : nhpi_host_checker
bind nhpi_host nhpi_host_checker chk_u (.core_clk_in, .reset_n_in, .chip_select_n_out, .cmd_latch_out,
  .addr_latch_out, .write_strobe_n_out, .read_strobe_n_out, .write_protect_n_out, .io_out, .io_oe_n_out,
  .ready_busy_in, .op_done_out, .rd_valid_out);

/* bench/testbench.sv */
// Self-checking bench: program, protected program, erase and read back through the flash model.
// Assumes the model's scaled busy times stay below the reduced busy timeout.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module testbench;
  import nhpi_pkg::*;
  logic core_clk_in = 0, reset_n_in = 0, op_valid_in = 0, op_write_protect_in = 0, wr_valid_in = 0, took = 0;
  logic [1:0] op_kind_in = 0;
  logic [11:0] op_col_in = 0, rd_count_in = 0;
  logic [15:0] op_row_in = 0, row;
  logic [7:0] wr_data_in = 0, io_out, io_m, io_in, rd_data_out, got, old_d [16];
  logic op_ready_out, wr_ready_out, rd_valid_out, op_done_out, op_timeout_out, cs_n, cle, ale, we_n, re_n, wp_n;
  logic io_oe_n, m_en, rb, m_err;
  logic [7:0] wq [$], exq [$];
  int err_total = 0, total_checks = 0, seed;
  always #12.5 core_clk_in = ~core_clk_in;
  assign io_in = !io_oe_n ? io_out : io_m;
  nhpi_host #(.BUSY_TIMEOUT_CYC(2000)) dut_u (.core_clk_in, .reset_n_in, .op_valid_in, .op_kind_in, .op_col_in,
    .op_row_in, .op_write_protect_in, .op_ready_out, .wr_data_in, .wr_valid_in, .wr_ready_out, .rd_data_out,
    .rd_valid_out, .rd_count_in, .op_done_out, .op_timeout_out, .chip_select_n_out(cs_n), .cmd_latch_out(cle),
    .addr_latch_out(ale), .write_strobe_n_out(we_n), .read_strobe_n_out(re_n), .write_protect_n_out(wp_n),
    .io_out, .io_oe_n_out(io_oe_n), .io_in, .ready_busy_in(rb));
  nhpi_flash_model flash_u (.cs_n_in(cs_n), .cle_in(cle), .ale_in(ale), .we_n_in(we_n), .re_n_in(re_n),
    .wp_n_in(wp_n), .io_in, .io_out(io_m), .io_en_out(m_en), .rb_out(rb), .err_out(m_err));
  // Write data source stalls at random so the data phase sees gaps.
  always @(posedge core_clk_in) took <= wr_valid_in && wr_ready_out;
  always @(negedge core_clk_in) begin
    if (took) void'(wq.pop_front());
    wr_valid_in = wq.size() > 0 && $urandom % 4 != 0;
    wr_data_in = wq.size() > 0 ? wq[0] : 8'($urandom);
  end
  always @(negedge core_clk_in) if (rd_valid_out === 1'b1) begin
    got = exq.size() > 0 ? exq.pop_front() : ~rd_data_out;
    `CHK("rd_data", got, rd_data_out)
  end
  task automatic run_op(input logic [1:0] k, input logic [11:0] c, input logic p, input logic [11:0] n);
    @(negedge core_clk_in);
    {op_valid_in, op_kind_in, op_col_in, op_row_in, op_write_protect_in, rd_count_in} = {1'b1, k, c, row, p, n};
    while (op_ready_out !== 1'b1) @(negedge core_clk_in);
    @(negedge core_clk_in);
    op_valid_in = 0;
    for (int i = 0; i < 20000 && op_done_out !== 1'b1; i++) @(negedge core_clk_in);
    `CHK("op_done", 1'b1, op_done_out)
    `CHK("op_timeout", 1'b0, op_timeout_out)
    @(negedge core_clk_in);
    `CHK("rd_left", 0, exq.size())
  endtask : run_op
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  initial begin
    #2000000;
    err_total++;
    stop_test();
  end
  initial begin
    seed = $urandom(39);
    repeat (8) @(negedge core_clk_in);
    reset_n_in = 1;
    repeat (4) @(negedge core_clk_in);
    `CHK("cs_n", 1'b1, cs_n)
    `CHK("io_oe_n", 1'b1, io_oe_n)
    `CHK("wp_n", 1'b0, wp_n)
    `CHK("op_ready", 1'b1, op_ready_out)
    row = 16'($urandom);
    foreach (old_d[i]) begin
      old_d[i] = 8'($urandom);
      wq.push_back(old_d[i]);
    end
    run_op(2'd1, 12'h830, 0, 0);
    foreach (old_d[i]) exq.push_back(old_d[i]);
    run_op(2'd0, 12'h830, 0, 12'd15);
    repeat (16) wq.push_back(8'($urandom));
    run_op(2'd1, 12'h830, 1, 0);
    foreach (old_d[i]) exq.push_back(old_d[i]);
    run_op(2'd0, 12'h830, 0, 12'd15);
    row = row ^ 16'h0001;
    run_op(2'd2, 12'h000, 0, 0);
    row = row ^ 16'h0001;
    repeat (2) exq.push_back(8'hff);
    run_op(2'd0, 12'h83e, 0, 12'd1);
    `CHK("protocol", 1'b0, m_err)
    stop_test();
  end
endmodule : testbench

/* logic/nhpi_cyc_if.sv */
// Interface between the sequencer and the pin cycle engine.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface nhpi_cyc_if;
  import nhpi_pkg::*;
  logic      req;
  nhpi_cyc_t kind;
  logic [7:0] wdata;
  logic      done;
  logic [7:0] rdata;
  modport seq (output req, output kind, output wdata, input done, input rdata);
  modport eng (input req, input kind, input wdata, output done, output rdata);
endinterface : nhpi_cyc_if

/* logic/nhpi_cycle_engine.sv */
// Pin cycle engine: one command, address, write or read bus cycle per request.
// Assumes io_in is already synchronised by the caller.
`timescale 1ns/1ps
module nhpi_cycle_engine
  import nhpi_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       reset_n_in,
  nhpi_cyc_if.eng         cyc,
  input  wire logic [7:0] io_sync_in,
  output logic            cle_out,
  output logic            ale_out,
  output logic            write_strobe_n_out,
  output logic            read_strobe_n_out,
  output logic [7:0]      io_o_out,
  output logic            io_oe_n_out
);
  typedef enum logic [1:0] {
    NHPI_E_IDLE = 2'b00,
    NHPI_E_LOW  = 2'b01,
    NHPI_E_HIGH = 2'b10
  } nhpi_eng_st_t;

  nhpi_eng_st_t st_q;
  logic [3:0]   cnt_q;
  logic         is_rd_q;
  logic [7:0]   rdata_q;
  logic         cle_q;
  logic         ale_q;
  logic         write_strobe_n_q;
  logic         read_strobe_n_q;
  logic [7:0]   io_o_q;
  logic         io_oe_n_q;

  assign cyc.done           = (st_q == NHPI_E_HIGH) && (cnt_q == 4'h0);
  assign cyc.rdata          = rdata_q;
  assign cle_out            = cle_q;
  assign ale_out            = ale_q;
  assign write_strobe_n_out = write_strobe_n_q;
  assign read_strobe_n_out  = read_strobe_n_q;
  assign io_o_out           = io_o_q;
  assign io_oe_n_out        = io_oe_n_q;

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      st_q             <= NHPI_E_IDLE;
      cnt_q            <= 4'h0;
      is_rd_q          <= 1'b0;
      cle_q            <= 1'b0;
      ale_q            <= 1'b0;
      write_strobe_n_q <= 1'b1;
      read_strobe_n_q  <= 1'b1;
      io_o_q           <= 8'h00;
      io_oe_n_q        <= 1'b1;
    end else begin
      case (st_q)
        NHPI_E_IDLE: begin
          if (cyc.req) begin
            st_q    <= NHPI_E_LOW;
            cnt_q   <= 4'(STROBE_LOW_CYC - 1);
            is_rd_q <= (cyc.kind == NHPI_CYC_RD);
            cle_q   <= (cyc.kind == NHPI_CYC_CMD);
            ale_q   <= (cyc.kind == NHPI_CYC_ADDR);
            io_o_q  <= cyc.wdata;
            if (cyc.kind == NHPI_CYC_RD) begin
              read_strobe_n_q <= 1'b0;
              io_oe_n_q       <= 1'b1;
            end else begin
              write_strobe_n_q <= 1'b0;
              io_oe_n_q        <= 1'b0;
            end
          end
        end
        NHPI_E_LOW: begin
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            st_q             <= NHPI_E_HIGH;
            cnt_q            <= 4'(STROBE_HIGH_CYC - 1);
            write_strobe_n_q <= 1'b1;
            read_strobe_n_q  <= 1'b1;
          end
        end
        NHPI_E_HIGH: begin
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            st_q      <= NHPI_E_IDLE;
            cle_q     <= 1'b0;
            ale_q     <= 1'b0;
            io_oe_n_q <= 1'b1;
          end
        end
        default: st_q <= NHPI_E_IDLE;
      endcase
    end
  end

  // The two sync flops delay the pin, so the byte seen mid low time arrives just after the strobe rises.
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      rdata_q <= 8'h00;
    end else if (st_q == NHPI_E_HIGH && cnt_q == 4'(STROBE_HIGH_CYC - 1) && is_rd_q) begin
      rdata_q <= io_sync_in;
    end
  end
endmodule : nhpi_cycle_engine

/* logic/nhpi_host.sv */
// NAND host pin controller: runs read, program and erase sequences on the flash pins.
// Assumes one flash device on the pins and a user that honours the handshakes below.
// What this block does
// - Eight shared I/O lines carry command, address, write data out and read data in.
// - Command byte is latched on rising write strobe with command latch high.
// - Address byte is latched on rising write strobe with address latch high.
// - In read and program, the first two address cycles carry column bits 0 to 11, low byte first.
// - Host drives upper four I/O lines low in the second column cycle.
// - Read and program send two column then two row address cycles.
// - Block erase sends only the two row address cycles.
`timescale 1ns/1ps
module nhpi_host
  import nhpi_pkg::*;
#(
  parameter int unsigned BUSY_TIMEOUT_CYC = BUSY_LIMIT_CYC
)
(
  input  wire logic        core_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        op_valid_in,
  input  wire logic [1:0]  op_kind_in,
  input  wire logic [11:0] op_col_in,
  input  wire logic [15:0] op_row_in,
  input  wire logic        op_write_protect_in,
  output logic             op_ready_out,
  input  wire logic [7:0]  wr_data_in,
  input  wire logic        wr_valid_in,
  output logic             wr_ready_out,
  output logic [7:0]       rd_data_out,
  output logic             rd_valid_out,
  input  wire logic [11:0] rd_count_in,
  output logic             op_done_out,
  output logic             op_timeout_out,
  output logic             chip_select_n_out,
  output logic             cmd_latch_out,
  output logic             addr_latch_out,
  output logic             write_strobe_n_out,
  output logic             read_strobe_n_out,
  output logic             write_protect_n_out,
  output logic [7:0]       io_out,
  output logic             io_oe_n_out,
  input  wire logic [7:0]  io_in,
  input  wire logic        ready_busy_in
);
  typedef enum logic [2:0] {
    NHPI_S_IDLE  = 3'b000,
    NHPI_S_CMD1  = 3'b001,
    NHPI_S_ADDR  = 3'b010,
    NHPI_S_DATA  = 3'b011,
    NHPI_S_CMD2  = 3'b100,
    NHPI_S_WAIT  = 3'b101,
    NHPI_S_RDATA = 3'b110
  } nhpi_st_t;

  nhpi_cyc_if cyc ();

  nhpi_st_t    st_q;
  nhpi_op_t    op_q;
  logic [11:0] col_q;
  logic [15:0] row_q;
  logic [1:0]  acnt_q;
  logic [11:0] dcnt_q;
  logic [11:0] rlast_q;
  logic        issued_q;
  logic        wp_n_q;
  logic [31:0] wait_q;
  logic        rb_meta_q;
  logic        rb_q;
  logic [7:0]  io_meta_q;
  logic [7:0]  io_sync_q;
  logic        rd_valid_q;
  logic [7:0]  rd_data_q;
  logic        done_q;
  logic        tmo_q;
  logic [7:0]  addr_byte;
  logic        can_issue;
  logic        last_addr;

  // The ready line and the bus come from the device, so both pass two flops first.
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      rb_meta_q <= 1'b1;
      rb_q      <= 1'b1;
      io_meta_q <= 8'h00;
      io_sync_q <= 8'h00;
    end else begin
      rb_meta_q <= ready_busy_in;
      rb_q      <= rb_meta_q;
      io_meta_q <= io_in;
      io_sync_q <= io_meta_q;
    end
  end

  nhpi_cycle_engine u_eng (
    .core_clk_in      (core_clk_in),
    .reset_n_in       (reset_n_in),
    .cyc              (cyc.eng),
    .io_sync_in       (io_sync_q),
    .cle_out            (cmd_latch_out),
    .ale_out            (addr_latch_out),
    .write_strobe_n_out (write_strobe_n_out),
    .read_strobe_n_out  (read_strobe_n_out),
    .io_o_out           (io_out),
    .io_oe_n_out        (io_oe_n_out)
  );

  always_comb begin
    case (acnt_q)
      2'd0:    addr_byte = (op_q == NHPI_OP_ERASE) ? row_q[7:0] : col_q[7:0];
      2'd1:    addr_byte = (op_q == NHPI_OP_ERASE) ? row_q[15:8] : {COL_HI_ZERO, col_q[11:8]};
      2'd2:    addr_byte = row_q[7:0];
      default: addr_byte = row_q[15:8];
    endcase
  end

  assign last_addr = (op_q == NHPI_OP_ERASE) ? (acnt_q == 2'd1) : (acnt_q == 2'd3);
  assign can_issue = !issued_q && !(st_q == NHPI_S_DATA && !wr_valid_in);
  assign cyc.req   = can_issue && (st_q inside {NHPI_S_CMD1, NHPI_S_ADDR, NHPI_S_DATA, NHPI_S_CMD2, NHPI_S_RDATA});

  always_comb begin
    case (st_q)
      NHPI_S_CMD1:  cyc.kind = NHPI_CYC_CMD;
      NHPI_S_CMD2:  cyc.kind = NHPI_CYC_CMD;
      NHPI_S_ADDR:  cyc.kind = NHPI_CYC_ADDR;
      NHPI_S_DATA:  cyc.kind = NHPI_CYC_WR;
      default:      cyc.kind = NHPI_CYC_RD;
    endcase
    case (st_q)
      NHPI_S_CMD1: cyc.wdata = (op_q == NHPI_OP_READ) ? CMD_READ_1 : (op_q == NHPI_OP_PROG) ? CMD_PROG_1 : CMD_ERASE_1;
      NHPI_S_CMD2: cyc.wdata = (op_q == NHPI_OP_READ) ? CMD_READ_2 : (op_q == NHPI_OP_PROG) ? CMD_PROG_2 : CMD_ERASE_2;
      NHPI_S_ADDR: cyc.wdata = addr_byte;
      NHPI_S_DATA: cyc.wdata = wr_data_in;
      default:     cyc.wdata = 8'h00;
    endcase
  end

  assign op_ready_out        = (st_q == NHPI_S_IDLE) && rb_q;
  assign wr_ready_out        = (st_q == NHPI_S_DATA) && can_issue;
  assign chip_select_n_out   = (st_q == NHPI_S_IDLE);
  assign write_protect_n_out = wp_n_q;
  assign rd_data_out         = rd_data_q;
  assign rd_valid_out        = rd_valid_q;
  assign op_done_out         = done_q;
  assign op_timeout_out      = tmo_q;

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      st_q     <= NHPI_S_IDLE;
      op_q     <= NHPI_OP_READ;
      col_q    <= 12'h000;
      row_q    <= 16'h0000;
      acnt_q   <= 2'd0;
      dcnt_q   <= 12'h000;
      rlast_q  <= 12'h000;
      issued_q <= 1'b0;
      wp_n_q   <= 1'b0;
      wait_q   <= 32'h0000_0000;
    end else begin
      if (cyc.req) begin
        issued_q <= 1'b1;
      end
      case (st_q)
        NHPI_S_IDLE: begin
          if (op_valid_in && rb_q) begin
            st_q    <= NHPI_S_CMD1;
            op_q    <= nhpi_op_t'(op_kind_in);
            col_q   <= op_col_in;
            row_q   <= op_row_in;
            rlast_q <= rd_count_in;
            wp_n_q  <= !op_write_protect_in;
            acnt_q  <= 2'd0;
            dcnt_q  <= op_col_in;
          end
        end
        NHPI_S_CMD1: if (cyc.done) begin
          issued_q <= 1'b0;
          st_q     <= NHPI_S_ADDR;
        end
        NHPI_S_ADDR: if (cyc.done) begin
          issued_q <= 1'b0;
          acnt_q   <= acnt_q + 2'd1;
          if (last_addr) begin
            st_q <= (op_q == NHPI_OP_PROG) ? NHPI_S_DATA : NHPI_S_CMD2;
          end
        end
        NHPI_S_DATA: if (cyc.done) begin
          issued_q <= 1'b0;
          dcnt_q   <= dcnt_q + 12'h001;
          if (dcnt_q == PAGE_LAST_COL) begin
            st_q <= NHPI_S_CMD2;
          end
        end
        NHPI_S_CMD2: if (cyc.done) begin
          issued_q <= 1'b0;
          wait_q   <= 32'h0000_0000;
          st_q     <= NHPI_S_WAIT;
        end
        NHPI_S_WAIT: begin
          // Busy is asserted some time after the confirm command, so a short settle is allowed.
          wait_q <= wait_q + 32'h0000_0001;
          if ((rb_q && wait_q > 32'h0000_0008) || wait_q == 32'(BUSY_TIMEOUT_CYC)) begin
            dcnt_q <= 12'h000;
            st_q   <= (op_q == NHPI_OP_READ && wait_q != 32'(BUSY_TIMEOUT_CYC)) ? NHPI_S_RDATA : NHPI_S_IDLE;
          end
        end
        NHPI_S_RDATA: if (cyc.done) begin
          issued_q <= 1'b0;
          dcnt_q   <= dcnt_q + 12'h001;
          if (dcnt_q == rlast_q) begin
            st_q <= NHPI_S_IDLE;
          end
        end
        default: st_q <= NHPI_S_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= 8'h00;
      done_q     <= 1'b0;
      tmo_q      <= 1'b0;
    end else begin
      rd_valid_q <= (st_q == NHPI_S_RDATA) && cyc.done;
      if ((st_q == NHPI_S_RDATA) && cyc.done) begin
        rd_data_q <= cyc.rdata;
      end
      done_q <= ((st_q == NHPI_S_RDATA) && cyc.done && dcnt_q == rlast_q) ||
                ((st_q == NHPI_S_WAIT) && op_q != NHPI_OP_READ && rb_q && wait_q > 32'h0000_0008);
      tmo_q  <= (st_q == NHPI_S_WAIT) && (wait_q == 32'(BUSY_TIMEOUT_CYC));
    end
  end
endmodule : nhpi_host

/* logic/nhpi_pkg.sv */
// Package for the NAND host pin controller: command codes, address layout, pin timing and busy limits.
// Assumes a 40 MHz core clock; cycle counts derive from the period below.
package nhpi_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned STROBE_LOW_NS   = 50;
  localparam int unsigned STROBE_HIGH_NS  = 50;
  localparam int unsigned STROBE_LOW_CYC  = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROG_TYP_US     = 200;
  localparam int unsigned ERASE_TYP_US    = 1500;
  localparam int unsigned BUSY_LIMIT_US   = 10 * ERASE_TYP_US;
  localparam int unsigned BUSY_LIMIT_CYC  = BUSY_LIMIT_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned PAGE_BYTES      = 2112;
  localparam logic [11:0] PAGE_LAST_COL   = 12'h83f;
  localparam logic [3:0]  COL_HI_ZERO     = 4'h0;
  localparam logic [7:0]  CMD_READ_1      = 8'h00;
  localparam logic [7:0]  CMD_READ_2      = 8'h30;
  localparam logic [7:0]  CMD_PROG_1      = 8'h80;
  localparam logic [7:0]  CMD_PROG_2      = 8'h10;
  localparam logic [7:0]  CMD_ERASE_1     = 8'h60;
  localparam logic [7:0]  CMD_ERASE_2     = 8'hd0;

  typedef enum logic [1:0] {
    NHPI_OP_READ  = 2'b00,
    NHPI_OP_PROG  = 2'b01,
    NHPI_OP_ERASE = 2'b10
  } nhpi_op_t;

  typedef enum logic [1:0] {
    NHPI_CYC_CMD  = 2'b00,
    NHPI_CYC_ADDR = 2'b01,
    NHPI_CYC_WR   = 2'b10,
    NHPI_CYC_RD   = 2'b11
  } nhpi_cyc_t;
endpackage : nhpi_pkg
